//--- rtl/oosc_ctrl.sv
// On/off switch controller: cycle timer, enable sampling, limit selection,
// blanking, auto-restart and line under-voltage gating.
// Assumes analog comparators deliver levels asynchronous to clk_i.
//
// Contract
// (RQ1) Over-current ends pulse until next cycle
// (RQ2) Limit lowered in discrete steps
// (RQ3) Ignore over-current during blanking time
// (RQ4) Restart counter cleared when enable low
// (RQ5) 50 ms without low: off 850 ms
// (RQ6) Alternate on/off windows while fault persists
// (RQ7) Under-voltage halts off-period counter
// (RQ8) Start only when line current sufficient
// (RQ9) No resistor fitted disables under-voltage gating
// (RQ10) On at start, off at limit/duty
// (RQ11) Started cycle always completes
// (RQ12) Sample enable at every cycle start
// (RQ13) Limit chosen from recent enable samples
// (RQ14) Full limit heavy, reduced when light
// (RQ15) Feedback holds enable high below reference
// (RQ16) Over 240 uA out gives disable
// (RQ17) 132 kHz oscillator, start and duty
// (RQ18) Limit fixed for whole cycle
`timescale 1ns/100ps
`include "oosc_regs.svh"
module oosc_ctrl #(
  parameter int CYCLE_CLKS = `OOSC_CYCLE_CLKS,
  parameter int DUTY_CLKS  = `OOSC_DUTY_CLKS,
  parameter int BLANK_CLKS = `OOSC_BLANK_CLKS,
  parameter int FAULT_CYC  = `OOSC_FAULT_CYC,
  parameter int OFF_CYC    = `OOSC_OFF_CYC,
  parameter int HIST_LEN   = `OOSC_HIST_LEN
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Sense comparators (asynchronous)
  input  wire oosc_pkg::oosc_sense_t sense_i,
  input  wire logic [2:0]          ocp_i,
  // Switch drive and status
  output logic                     gate_o,
  output oosc_pkg::oosc_lim_t      limit_o,
  output logic                     cycle_start_o,
  output logic                     max_duty_limit_o,
  output logic                     restart_off_o
);
  import oosc_pkg::*;

  localparam int CW = $clog2(CYCLE_CLKS + 1);
  localparam int FW = $clog2(OFF_CYC + FAULT_CYC + 1);

  // Two-flop synchronisers for all asynchronous inputs
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {ocp_i, sense_i};
      sync2_r <= sync1_r;
    end
  end
  logic       en_high;
  logic       uv_ok;
  logic       no_res;
  logic [2:0] ocp;
  assign en_high = sync2_r[2]; // RQ16
  assign uv_ok   = sync2_r[1];
  assign no_res  = sync2_r[0];
  assign ocp     = sync2_r[5:3];

  // Free-running oscillator
  logic [CW-1:0] cyc_cnt_r;
  logic          cyc_start;
  assign cyc_start = (cyc_cnt_r == CW'(CYCLE_CLKS - 1));
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cyc_cnt_r <= '0;
    end else if (cyc_start) begin // RQ17
      cyc_cnt_r <= '0;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + CW'(1);
    end
  end
  logic duty_end;
  assign duty_end = (cyc_cnt_r == CW'(DUTY_CLKS - 1));

  // Line gating: resistor absent disables under-voltage check
  logic line_ok;
  assign line_ok = no_res | uv_ok; // RQ8 RQ9

  // Auto-restart: counts oscillator cycles
  logic [FW-1:0] ar_cnt_r;
  logic          ar_off_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ar_cnt_r <= '0;
      ar_off_r <= 1'b0;
    end else if (cyc_start) begin
      if (ar_off_r) begin
        if (!line_ok) begin
          ar_cnt_r <= ar_cnt_r; // RQ7
        end else if (ar_cnt_r >= FW'(OFF_CYC - 1)) begin
          ar_off_r <= 1'b0; // RQ6
          ar_cnt_r <= '0;
        end else begin
          ar_cnt_r <= ar_cnt_r + FW'(1);
        end
      end else if (!en_high) begin
        ar_cnt_r <= '0; // RQ4
      end else if (ar_cnt_r >= FW'(FAULT_CYC - 1)) begin
        ar_off_r <= 1'b1; // RQ5
        ar_cnt_r <= '0;
      end else begin
        ar_cnt_r <= ar_cnt_r + FW'(1); // RQ4
      end
    end
  end

  // Enable sample history and limit selection
  logic [HIST_LEN-1:0] hist_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hist_r <= {HIST_LEN{1'b1}};
    end else if (cyc_start) begin
      hist_r <= {hist_r[HIST_LEN-2:0], en_high}; // RQ12 RQ13
    end
  end
  logic [$clog2(HIST_LEN+1)-1:0] ones;
  always_comb begin
    ones = '0;
    for (int i = 0; i < HIST_LEN; i++) begin
      ones = ones + {{($clog2(HIST_LEN+1)-1){1'b0}}, hist_r[i]};
    end
  end
  oosc_lim_t lim_nxt;
  always_comb begin
    if (ones >= $bits(ones)'(`OOSC_MED_THR)) begin
      lim_nxt = OOSC_LIM_FULL; // RQ14
    end else if (ones >= $bits(ones)'(`OOSC_LIGHT_THR)) begin
      lim_nxt = OOSC_LIM_MED; // RQ2
    end else begin
      lim_nxt = OOSC_LIM_LIGHT; // RQ2
    end
  end
  oosc_lim_t lim_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lim_r <= OOSC_LIM_FULL;
    end else if (cyc_start) begin
      lim_r <= lim_nxt; // RQ18
    end
  end

  // Power-up hold until line is acceptable
  logic started_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      started_r <= 1'b0;
    end else if (line_ok) begin
      started_r <= 1'b1; // RQ8
    end
  end

  // Switch pulse: on at cycle start, off at over-current or duty limit
  logic                  gate_r;
  logic [CW-1:0]         blank_r;
  logic                  ocp_hit;
  always_comb begin
    case (lim_r)
      OOSC_LIM_FULL:  ocp_hit = ocp[0];
      OOSC_LIM_MED:   ocp_hit = ocp[1];
      OOSC_LIM_LIGHT: ocp_hit = ocp[2];
      default:        ocp_hit = ocp[0];
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gate_r  <= 1'b0;
      blank_r <= '0;
    end else if (cyc_start) begin
      gate_r  <= en_high && !ar_off_r && started_r; // RQ10 RQ11 RQ12
      blank_r <= CW'(BLANK_CLKS);
    end else begin
      if (blank_r != '0) begin
        blank_r <= blank_r - CW'(1); // RQ3
      end
      if (duty_end) begin
        gate_r <= 1'b0; // RQ10
      end else if (ocp_hit && blank_r == '0) begin
        gate_r <= 1'b0; // RQ1 RQ3
      end
    end
  end
  // Registered outputs
  logic start_r;
  logic duty_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_r <= 1'b0;
      duty_r  <= 1'b0;
    end else begin
      start_r <= cyc_start;
      duty_r  <= duty_end;
    end
  end
  assign gate_o           = gate_r;
  assign limit_o          = lim_r;
  assign cycle_start_o    = start_r;
  assign max_duty_limit_o = duty_r;
  assign restart_off_o    = ar_off_r;
endmodule // oosc_ctrl

//--- rtl/oosc_regs.svh
// Timing and level constants for the on/off switch controller.
// Assumes a 100 MHz clk_i; times are given in their own units.
`ifndef OOSC_REGS_SVH
`define OOSC_REGS_SVH
`define OOSC_CLK_MHZ          100
`define OOSC_OSC_KHZ          132
`define OOSC_CYCLE_CLKS       ((`OOSC_CLK_MHZ * 1000) / `OOSC_OSC_KHZ)
`define OOSC_DUTY_PCT         65
`define OOSC_DUTY_CLKS        ((`OOSC_CYCLE_CLKS * `OOSC_DUTY_PCT) / 100)
`define OOSC_BLANK_NS         200
`define OOSC_BLANK_CLKS       ((`OOSC_BLANK_NS * `OOSC_CLK_MHZ + 999) / 1000)
`define OOSC_FAULT_MS         50
`define OOSC_OFF_MS           850
`define OOSC_FAULT_CYC        ((`OOSC_FAULT_MS * `OOSC_OSC_KHZ))
`define OOSC_OFF_CYC          ((`OOSC_OFF_MS * `OOSC_OSC_KHZ))
`define OOSC_HIST_LEN         8
`define OOSC_MED_THR          5
`define OOSC_LIGHT_THR        2
`endif

//--- rtl/oosc_pkg.sv
// Types for the on/off switch controller.
// Assumes oosc_regs.svh supplies the numeric constants.
package oosc_pkg;
  typedef enum logic [1:0] {
    OOSC_LIM_FULL,
    OOSC_LIM_MED,
    OOSC_LIM_LIGHT
  } oosc_lim_t;

  typedef struct packed {
    logic en_high;
    logic uv_ok;
    logic no_resistor;
  } oosc_sense_t;
endpackage

//--- verif/oosc_fb.sv
// Feedback side: optocoupler and line resistor.
// Assumes levels set by the bench.
`timescale 1ns/100ps
module oosc_fb import oosc_pkg::*; (
  input  logic        out_low_i,
  input  logic        res_fit_i,
  input  logic        line_hi_i,
  output oosc_sense_t sense_o
);
  assign sense_o = '{out_low_i, res_fit_i & line_hi_i, !res_fit_i};
endmodule // oosc_fb

//--- verif/oosc_checker.sv
// Port assertions for oosc_ctrl.
// Assumes the bind below.
`timescale 1ns/100ps
module oosc_checker import oosc_pkg::*; #(parameter int DUTY_CLKS = 26) (
  input logic       clk_i,
  input logic       srst_i,
  input logic [2:0] ocp_i,
  input logic       gate_o,
  input oosc_lim_t  limit_o,
  input logic       cycle_start_o,
  input logic       max_duty_limit_o,
  input logic       restart_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_gate_start: assert property ($rose(gate_o) |-> cycle_start_o) else $error("start");
  a_duty_cap: assert property ($rose(gate_o) |-> ##[1:DUTY_CLKS] !gate_o) else $error("duty");
  a_duty_flag: assert property (max_duty_limit_o |-> !gate_o) else $error("flag");
  a_limit_step: assert property ($changed(limit_o) |-> limit_o == OOSC_LIM_MED || $past(limit_o) == OOSC_LIM_MED)
    else $error("step");
  a_blank_hold: assert property ($rose(gate_o) |=> gate_o [*3]) else $error("blank");
  a_off_start: assert property ($rose(gate_o) |-> !$past(restart_off_o)) else $error("off");
  a_ocp_end: assert property (gate_o && $past(gate_o, 5) && ocp_i == 3'h7 |-> ##[1:4] !gate_o) else $error("ocp");
  a_off_hold: assert property ($fell(gate_o) |=> !gate_o [*8]) else $error("hold");
endmodule // oosc_checker
bind oosc_ctrl oosc_checker #(.DUTY_CLKS(DUTY_CLKS)) chk (.clk_i, .srst_i, .ocp_i, .gate_o, .limit_o,
  .cycle_start_o, .max_duty_limit_o, .restart_off_o);

//--- verif/testbench.sv
// Bench for oosc_ctrl, shortened counts.
// Assumes the oosc_fb model.
`timescale 1ns/100ps
module testbench;
  import oosc_pkg::*;
  logic        clk_i = 0, srst_i = 1, en = 1, fit = 1, lhi = 0, gate_o, cs, md, off;
  logic [2:0]  ocp_i = 3'h0;
  oosc_sense_t sense_i;
  oosc_lim_t   limit_o;
  int          err_total = 0, tests_run = 0, n;
  initial forever #5 clk_i = ~clk_i;
  oosc_fb fb (.out_low_i(en), .res_fit_i(fit), .line_hi_i(lhi), .sense_o(sense_i));
  oosc_ctrl #(.CYCLE_CLKS(40), .DUTY_CLKS(26), .BLANK_CLKS(3), .FAULT_CYC(10), .OFF_CYC(20)) dut (.clk_i, .srst_i,
    .sense_i, .ocp_i, .gate_o, .limit_o, .cycle_start_o(cs), .max_duty_limit_o(md), .restart_off_o(off));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i) #1;
  endtask
  task automatic chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wcs;
    for (n = 0; n < 99 && cs !== 1; n++) cyc(1);
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      cyc(1);
      chk(gate_o, 0);
    end
  endtask
  task automatic t_light;
    quiet(120);
    lhi = 1;
    en = 0;
    quiet(400);
    chk(limit_o, OOSC_LIM_LIGHT);
  endtask
  task automatic t_ocp;
    en = 1;
    ocp_i = 3'h7;
    cyc(3);
    wcs;
    cyc(3);
    chk(gate_o, 1);
    cyc(6);
    chk(gate_o, 0);
  endtask
  task automatic t_fault;
    for (n = 0; n < 480 && off !== 1; n++) cyc(1);
    chk(off, 1);
    lhi = 0;
    cyc(1000);
    chk(off, 1);
    fit = 0;
    for (n = 0; n < 880 && off !== 0; n++) cyc(1);
    chk(off, 0);
    cyc(1);
    wcs;
    chk(gate_o, 1);
  endtask
  task automatic t_duty;
    ocp_i = 3'h0;
    cyc(3);
    wcs;
    chk(limit_o, OOSC_LIM_FULL);
    cyc(25);
    chk(gate_o, 1);
    cyc(1);
    chk(gate_o, 0);
    chk(md, 1);
    cyc(1);
    chk(md, 0);
  endtask
  task automatic conclude;
    $display("err %0d of %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    srst_i = 0;
    t_light;
    t_ocp;
    t_fault;
    t_duty;
    conclude;
  end
  initial begin
    #100_000;
    err_total++;
    conclude;
  end
endmodule // testbench
